// ==== common/ctrb_pkg.sv ====
package ctrb_pkg;

  // Register offsets on the device control port
  localparam logic [7:0] CTRB_OFS_CH4_PHASE = 8'h4F;
  localparam logic [7:0] CTRB_OFS_CH5_VOL   = 8'h52;
  localparam logic [7:0] CTRB_OFS_CH5_TRIM  = 8'h53;
  localparam logic [7:0] CTRB_OFS_CH5_PHASE = 8'h54;
  localparam logic [7:0] CTRB_OFS_CH6_VOL   = 8'h57;

  // Reset values
  localparam logic [7:0] CTRB_RST_PHASE = 8'h00;
  localparam logic [7:0] CTRB_RST_VOL   = 8'hC9;
  localparam logic [7:0] CTRB_RST_TRIM  = 8'h80;

  // Field layout of the gain trim register
  localparam int         CTRB_TRIM_LSB  = 4;
  localparam int         CTRB_TRIM_MSB  = 7;

  // Code points of the decibel mappings
  localparam logic [7:0] CTRB_VOL_MUTE  = 8'h00;
  localparam logic [7:0] CTRB_VOL_UNITY = 8'hC9;
  localparam logic [3:0] CTRB_TRIM_ZERO = 4'h8;

  // Longest phase delay in modulator cycles
  localparam int         CTRB_MAX_DELAY = 255;

  // Register access request from the control port
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } ctrb_req_t;

  // Effective trim of one channel as seen by the signal chain
  typedef struct packed {
    logic              mute;
    logic signed [8:0] vol_half_db;
    logic signed [4:0] trim_tenth_db;
    logic [7:0]        delay_code;
  } ctrb_trim_t;

endpackage

// ==== design/ctrb_channel_trim_register_bank.sv ====
`timescale 1ns/1ps
`default_nettype none

module ctrb_channel_trim_register_bank
  import ctrb_pkg::*;
#(
  parameter int MAX_DELAY = CTRB_MAX_DELAY
) (
  input  wire logic        core_clk_i,
  input  wire logic        rstn_i,
  input  wire ctrb_req_t   req_i,
  output var  logic [7:0]  rdata_o,
  output var  logic        rvalid_o,
  input  wire logic        ch5_pdm_mode_i,
  input  wire logic        ch6_pdm_mode_i,
  input  wire logic        mod_tick_i,
  input  wire logic        ch4_bit_i,
  input  wire logic        ch5_bit_i,
  output var  logic        ch4_bit_o,
  output var  logic        ch5_bit_o,
  output var  ctrb_trim_t  ch4_trim_o,
  output var  ctrb_trim_t  ch5_trim_o,
  output var  ctrb_trim_t  ch6_trim_o
);

  // The tap select is eight bits wide, so deeper lines cannot be reached
  if (MAX_DELAY < 1 || MAX_DELAY > CTRB_MAX_DELAY) begin : g_bad_depth
    $error("MAX_DELAY must lie between 1 and 255");
  end

  // Stored register contents
  logic [7:0] ch4_phase_delay_r;
  logic [7:0] ch5_volume_level_r;
  logic [3:0] ch5_gain_trim_code_r;
  logic [7:0] ch5_phase_delay_r;
  logic [7:0] ch6_volume_level_r;

  // Address decode
  wire logic hit_ch4_phase = (req_i.addr == CTRB_OFS_CH4_PHASE);
  wire logic hit_ch5_vol   = (req_i.addr == CTRB_OFS_CH5_VOL);
  wire logic hit_ch5_trim  = (req_i.addr == CTRB_OFS_CH5_TRIM);
  wire logic hit_ch5_phase = (req_i.addr == CTRB_OFS_CH5_PHASE);
  wire logic hit_ch6_vol   = (req_i.addr == CTRB_OFS_CH6_VOL);

  // Read mux; unmapped offsets and reserved bits return zero
  logic [7:0] rd_mux;
  always_comb begin
    if (hit_ch4_phase) begin
      rd_mux = ch4_phase_delay_r;
    end else if (hit_ch5_vol) begin
      rd_mux = ch5_volume_level_r;
    end else if (hit_ch5_trim) begin
      rd_mux = {ch5_gain_trim_code_r, 4'h0};
    end else if (hit_ch5_phase) begin
      rd_mux = ch5_phase_delay_r;
    end else if (hit_ch6_vol) begin
      rd_mux = ch6_volume_level_r;
    end else begin
      rd_mux = 8'h00;
    end
  end

  // Register writes; a write to an unmapped offset is dropped
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      ch4_phase_delay_r    <= CTRB_RST_PHASE;
      ch5_phase_delay_r    <= CTRB_RST_PHASE;
      ch5_volume_level_r   <= CTRB_RST_VOL;
      ch6_volume_level_r   <= CTRB_RST_VOL;
      ch5_gain_trim_code_r <= CTRB_RST_TRIM[CTRB_TRIM_MSB:CTRB_TRIM_LSB];
    end else if (req_i.wr) begin
      if (hit_ch4_phase) begin
        ch4_phase_delay_r <= req_i.wdata;
      end
      if (hit_ch5_vol) begin
        ch5_volume_level_r <= req_i.wdata;
      end
      if (hit_ch5_trim) begin
        ch5_gain_trim_code_r <= req_i.wdata[CTRB_TRIM_MSB:CTRB_TRIM_LSB];
      end
      if (hit_ch5_phase) begin
        ch5_phase_delay_r <= req_i.wdata;
      end
      if (hit_ch6_vol) begin
        ch6_volume_level_r <= req_i.wdata;
      end
    end
  end

  // Read answer one cycle after the strobe; read wins nothing over write order
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      rdata_o  <= 8'h00;
      rvalid_o <= 1'b0;
    end else begin
      rvalid_o <= req_i.rd;
      if (req_i.rd) begin
        rdata_o <= rd_mux;
      end
    end
  end

  // Settings of channels 5 and 6 fall back to neutral outside PDM mode
  wire logic [7:0] ch5_vol_eff   = ch5_pdm_mode_i ? ch5_volume_level_r   : CTRB_VOL_UNITY;
  wire logic [3:0] ch5_trim_eff  = ch5_pdm_mode_i ? ch5_gain_trim_code_r : CTRB_TRIM_ZERO;
  wire logic [7:0] ch5_phase_eff = ch5_pdm_mode_i ? ch5_phase_delay_r    : CTRB_RST_PHASE;
  wire logic [7:0] ch6_vol_eff   = ch6_pdm_mode_i ? ch6_volume_level_r   : CTRB_VOL_UNITY;

  // Linear decibel mappings: half-dB from volume, tenth-dB from trim
  function automatic logic signed [8:0] vol_to_half_db(input logic [7:0] code);
    vol_to_half_db = $signed({1'b0, code}) - $signed({1'b0, CTRB_VOL_UNITY});
  endfunction

  function automatic logic signed [4:0] trim_to_tenth_db(input logic [3:0] code);
    trim_to_tenth_db = $signed({1'b0, code}) - $signed({1'b0, CTRB_TRIM_ZERO});
  endfunction

  // Channel 4 has no volume or trim in this bank, so it reports neutral values
  wire ctrb_trim_t ch4_trim_nxt = '{mute:          1'b0,
                                     vol_half_db:   9'sh000,
                                     trim_tenth_db: 5'sh00,
                                     delay_code:    ch4_phase_delay_r};
  wire ctrb_trim_t ch5_trim_nxt = '{mute:          (ch5_vol_eff == CTRB_VOL_MUTE),
                                     vol_half_db:   vol_to_half_db(ch5_vol_eff),
                                     trim_tenth_db: trim_to_tenth_db(ch5_trim_eff),
                                     delay_code:    ch5_phase_eff};
  wire ctrb_trim_t ch6_trim_nxt = '{mute:          (ch6_vol_eff == CTRB_VOL_MUTE),
                                     vol_half_db:   vol_to_half_db(ch6_vol_eff),
                                     trim_tenth_db: 5'sh00,
                                     delay_code:    CTRB_RST_PHASE};

  // Registered trim outputs so the filter path sees glitch-free codes
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      ch4_trim_o <= '{mute: 1'b0, vol_half_db: 9'sh000, trim_tenth_db: 5'sh00, delay_code: CTRB_RST_PHASE};
      ch5_trim_o <= '{mute: 1'b0, vol_half_db: 9'sh000, trim_tenth_db: 5'sh00, delay_code: CTRB_RST_PHASE};
      ch6_trim_o <= '{mute: 1'b0, vol_half_db: 9'sh000, trim_tenth_db: 5'sh00, delay_code: CTRB_RST_PHASE};
    end else begin
      ch4_trim_o <= ch4_trim_nxt;
      ch5_trim_o <= ch5_trim_nxt;
      ch6_trim_o <= ch6_trim_nxt;
    end
  end

  // Phase delay lines for channels 4 and 5, one modulator cycle per tick
  logic [1:0] dly_in;
  logic [7:0] dly_code [2];
  // Each lane owns its output flop; this net only gathers them
  wire logic [1:0] dly_out;
  assign dly_in      = {ch5_bit_i, ch4_bit_i};
  assign dly_code[0] = ch4_phase_delay_r;
  assign dly_code[1] = ch5_phase_eff;

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_dly
      // History of past bits; tap k holds the bit from k ticks ago
      logic [MAX_DELAY-1:0] hist_r;
      logic [MAX_DELAY:0]   taps;
      logic [7:0]           sel;
      logic                 out_r;
      assign taps = {hist_r, dly_in[g]};
      // Codes beyond the built depth saturate at the deepest tap
      assign sel  = (dly_code[g] > 8'(MAX_DELAY)) ? 8'(MAX_DELAY) : dly_code[g];

      always_ff @(posedge core_clk_i) begin
        if (!rstn_i) begin
          hist_r <= '0;
          out_r  <= 1'b0;
        end else if (mod_tick_i) begin
          hist_r <= taps[MAX_DELAY-1:0];
          out_r  <= taps[sel];
        end
      end
      assign dly_out[g] = out_r;
    end
  endgenerate

  assign ch4_bit_o = dly_out[0];
  assign ch5_bit_o = dly_out[1];

endmodule

`default_nettype wire

// ==== verification/ctrb_chk_sva.sv ====
`timescale 1ns/1ps
`default_nettype none
module ctrb_chk_sva
  import ctrb_pkg::*;
(
  input wire logic       core_clk_i,
  input wire logic       rstn_i,
  input wire ctrb_req_t  req_i,
  input wire logic [7:0] rdata_o,
  input wire logic       rvalid_o,
  input wire logic       ch5_pdm_mode_i,
  input wire logic       ch6_pdm_mode_i,
  input wire logic       mod_tick_i,
  input wire logic       ch4_bit_i,
  input wire logic       ch4_bit_o,
  input wire ctrb_trim_t ch4_trim_o,
  input wire ctrb_trim_t ch5_trim_o,
  input wire ctrb_trim_t ch6_trim_o
);
  // One clock domain; reset silences every check
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rstn_i);
  // Trim outputs trail a write by two edges; the checks look three edges on, so the mode must hold that long
  a_read_valid_pulse: assert property (1'b1 |=> rvalid_o == $past(req_i.rd))
    else $error("read valid timing");
  a_trim_read_zero: assert property (req_i.rd && req_i.addr == 8'h53 |=> rdata_o[3:0] == 4'h0)
    else $error("trim low bits set");
  a_gain_trim_map: assert property ((req_i.wr && req_i.addr == 8'h53) ##1 ch5_pdm_mode_i[*3] |->
    ch5_trim_o.trim_tenth_db == $signed({1'b0, $past(req_i.wdata[7:4], 3)}) - 5'sd8) else $error("gain map");
  a_volume_code_map: assert property ((req_i.wr && req_i.addr == 8'h57 && req_i.wdata != 8'h00)
    ##1 ch6_pdm_mode_i[*3] |-> ch6_trim_o.vol_half_db == $signed({1'b0, $past(req_i.wdata, 3)}) - 9'sd201)
    else $error("volume map");
  a_volume_zero_mute: assert property ((req_i.wr && req_i.addr == 8'h52 && req_i.wdata == 8'h00)
    ##1 ch5_pdm_mode_i[*3] |-> ch5_trim_o.mute) else $error("volume zero not muted");
  a_pcm_mode_neutral: assert property ((!ch6_pdm_mode_i)[*2] |-> ch6_trim_o.vol_half_db == 9'sd0
    && !ch6_trim_o.mute) else $error("setting active outside pdm mode");
  a_zero_delay_pass: assert property ((mod_tick_i && ch4_trim_o.delay_code == 8'h00)
    ##1 ch4_trim_o.delay_code == 8'h00 |-> ch4_bit_o == $past(ch4_bit_i)) else $error("zero delay added");
  a_bit_holds_tick: assert property (!mod_tick_i |=> $stable(ch4_bit_o))
    else $error("bit moved without tick");
endmodule
bind ctrb_channel_trim_register_bank ctrb_chk_sva u_ctrb_chk_sva (.core_clk_i(core_clk_i), .rstn_i(rstn_i),
  .req_i(req_i), .rdata_o(rdata_o), .rvalid_o(rvalid_o), .ch5_pdm_mode_i(ch5_pdm_mode_i),
  .ch6_pdm_mode_i(ch6_pdm_mode_i), .mod_tick_i(mod_tick_i), .ch4_bit_i(ch4_bit_i), .ch4_bit_o(ch4_bit_o),
  .ch4_trim_o(ch4_trim_o), .ch5_trim_o(ch5_trim_o), .ch6_trim_o(ch6_trim_o));
`default_nettype wire

// ==== verification/ctrb_channel_trim_register_bank_test.sv ====
`timescale 1ns/1ps
`default_nettype none
module ctrb_channel_trim_register_bank_test
  import ctrb_pkg::*;
;
  logic        clk, rstn, pdm5, pdm6, tick, b4, b5, o4, o5, rv;
  logic [7:0]  rd;
  ctrb_req_t   req;
  ctrb_trim_t  t4, t5, t6;
  int          n_errors = 0, total_checks = 0, k;
  localparam logic [15:0] PAT = 16'h000D;
  // Rows: offset, written value, value read back (0x60 is unmapped)
  logic [23:0] rows [6] = '{24'h4FFFFF, 24'h53FFF0, 24'h520000, 24'h540505, 24'h571010, 24'h60AA00};

  ctrb_channel_trim_register_bank u_ctrb_channel_trim_register_bank (.core_clk_i(clk), .rstn_i(rstn),
    .req_i(req), .rdata_o(rd), .rvalid_o(rv), .ch5_pdm_mode_i(pdm5), .ch6_pdm_mode_i(pdm6), .mod_tick_i(tick),
    .ch4_bit_i(b4), .ch5_bit_i(b5), .ch4_bit_o(o4), .ch5_bit_o(o5), .ch4_trim_o(t4), .ch5_trim_o(t5),
    .ch6_trim_o(t6));

  // Core clock, 40 ns period
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic chk(input logic [8:0] s, e);
    total_checks++;
    if (s !== e) begin
      n_errors++;
      $display("Error %0t: got %h expected %h", $time, s, e);
    end
  endtask
  // One access; on a read d is the expected data, sampled just after the answer edge
  task automatic acc(input logic w, input logic [7:0] a, d);
    @(posedge clk) req <= '{w, !w, a, d};
    @(posedge clk) req <= '0;
    #1;
    if (!w) chk(rd, d);
    chk(rv, !w);
  endtask
  task automatic rst;
    @(posedge clk) rstn <= 1'b0;
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
  endtask
  task automatic results;
    if (n_errors == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // Run takes about 70 cycles; this cuts a hang short
  initial begin
    #20000;
    n_errors++;
    results;
  end

  initial begin
    {rstn, pdm5, pdm6, tick, b4, b5} = 6'h18;
    req = '0;
    rst;
    foreach (rows[i]) begin
      acc(1'b1, rows[i][23:16], rows[i][15:8]);
      acc(1'b0, rows[i][23:16], rows[i][7:0]);
    end
    chk(t5.mute, 9'h001);
    chk(t5.vol_half_db, 9'h137);
    chk(t6.vol_half_db, 9'h147);
    chk(t5.trim_tenth_db, 9'h007);
    chk(t5.delay_code, 9'h005);
    chk(t4.delay_code, 9'h0FF);
    @(posedge clk) {pdm5, pdm6} <= 2'b00;
    repeat (3) @(posedge clk);
    #1;
    chk(t6.vol_half_db, 9'h000);
    chk(t5.mute, 9'h000);
    chk(t5.trim_tenth_db, 9'h000);
    chk(t5.delay_code, 9'h000);
    acc(1'b0, 8'h52, 8'h00);
    @(posedge clk) {pdm5, pdm6} <= 2'b11;
    acc(1'b1, 8'h4F, 8'h00);
    acc(1'b1, 8'h54, 8'h03);
    // A tick every cycle; history before the first tick is all zeros
    for (k = 0; k < 10; k++) begin
      @(posedge clk) {tick, b4, b5} <= {1'b1, PAT[k], PAT[k]};
      #1;
      chk(o4, k > 0 ? PAT[k-1] : 1'b0);
      chk(o5, k > 3 ? PAT[k-4] : 1'b0);
    end
    @(posedge clk) tick <= 1'b0;
    // Second reset in mid-run, over written values
    rst;
    acc(1'b0, 8'h4F, 8'h00);
    acc(1'b0, 8'h52, 8'hC9);
    acc(1'b0, 8'h53, 8'h80);
    acc(1'b0, 8'h54, 8'h00);
    acc(1'b0, 8'h57, 8'hC9);
    chk(t5.vol_half_db, 9'h000);
    chk(t5.trim_tenth_db, 9'h000);
    results;
  end
endmodule
`default_nettype wire
